// ### rtl/pwm_timer_defs.svh
`ifndef PWM_TIMER_DEFS_SVH
`define PWM_TIMER_DEFS_SVH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define ADDR_PLL_CONTROL_STATUS 8'h29
`define ADDR_FLAGS              8'h2A
`define ADDR_TOP_COMPARE        8'h2B
`define ADDR_CHANNEL_B_COMPARE  8'h2C
`define ADDR_CHANNEL_A_COMPARE  8'h2D
`define ADDR_COUNT_VALUE        8'h2E
`define ADDR_TIMER_CONTROL_B    8'h2F
`define ADDR_TIMER_CONTROL_A    8'h30

// ----------------------------------------
// field positions
// ----------------------------------------
`define PLL_FAST_SELECT_BIT 2
`define PLL_ON_BIT          1
`define PLL_LOCK_BIT        0
`define CTLA_MODE_A_LSB     6
`define CTLA_MODE_B_LSB     4
`define CTLA_FORCE_A_BIT    3
`define CTLA_FORCE_B_BIT    2
`define CTLA_PWM_A_BIT      1
`define CTLA_PWM_B_BIT      0
`define CTLB_CLEAR_TOP_BIT  7
`define CTLB_PRESCALE_RST   6
`define FLAG_OVERFLOW_BIT   2
`define FLAG_MATCH_A_BIT    1
`define FLAG_MATCH_B_BIT    0

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define COUNT_RESET     8'h00
`define TOP_RESET       8'hFF
`define CLK_MHZ         25
`define LOCK_TIME_US    100
`define LOCK_CYCLES     (`LOCK_TIME_US * `CLK_MHZ)

`endif

// ### rtl/pwm_timer_pkg.sv
package pwm_timer_pkg;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {
		MODE_OFF    = 2'b00,
		MODE_TOGGLE = 2'b01,
		MODE_CLEAR  = 2'b10,
		MODE_SET    = 2'b11
	} output_mode_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

	typedef struct packed {
		logic true_out;
		logic true_on;
		logic inv_out;
		logic inv_on;
	} pwm_pair_t;

	typedef struct packed {
		logic [7:0] buf_a;
		logic [7:0] buf_b;
		logic [7:0] act_a;
		logic [7:0] act_b;
	} compare_state_t;

endpackage

// ### rtl/compare_store.sv
`timescale 1ns/100ps

module compare_store (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       wr_a,
	input  wire logic       wr_b,
	input  wire logic [7:0] wdata,
	input  wire logic       pwm_a,
	input  wire logic       pwm_b,
	input  wire logic       latch,
	output logic      [7:0] active_a,
	output logic      [7:0] active_b,
	output logic      [7:0] shown_a,
	output logic      [7:0] shown_b
);
	import pwm_timer_pkg::*;

	compare_state_t s;
	compare_state_t next_s;

	// ----------------------------------------
	// buffered compare values
	// ----------------------------------------
	always_comb begin
		next_s = s;
		if (latch) begin
			next_s.act_a = s.buf_a;
			next_s.act_b = s.buf_b;
		end
		if (wr_a) begin
			next_s.buf_a = wdata;
			if (!pwm_a)
				next_s.act_a = wdata;
		end
		if (wr_b) begin
			next_s.buf_b = wdata;
			if (!pwm_b)
				next_s.act_b = wdata;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			s <= '0;
		else
			s <= next_s;
	end

	assign active_a = s.act_a;
	assign active_b = s.act_b;
	// reads see the latest write, not the live value
	assign shown_a  = s.buf_a;
	assign shown_b  = s.buf_b;

endmodule

// ### rtl/dual_pwm_timer.sv
// Our own choice: the plain strobed port.
`timescale 1ns/100ps
`include "pwm_timer_defs.svh"

// Summary of operation
// - top compare value is an 8-bit read/write register compared with count
// - matches come only from counting up, never from a software write
// - with clear on top, a top match clears count and sets overflow flag
// - pll register bits 7..3 read zero; lock flag is read only
// - fast clock select picks the fast tick, otherwise the system clock
// - fast clock select can be one only while pll is on
// - pll on starts the pll; reads one while pll drives system clock
// - lock flag rises a worst-case lock time after pll enable
// - pwm mode counts 0 to top, restarts, sets overflow after top match
// - true and inverted outputs of a channel are never both high
// - rising edges delayed prescaled plus source cycle (mode 10 one cycle), falling one cycle
// - mode 01 drives a complementary pair with dead time
// - mode 10 drives true output only, set at one, clear on match
// - mode 11 sets after match, clears at one; mode 00 disconnects
// - pwm compare writes go to a buffer copied in at top
// - compare reads return the most recently written value
// - compare equal zero or top holds outputs at static levels
// - flags in pwm mode behave as in normal mode
// - pwm period is top plus one timer clock cycles
// - pwm enable puts channel in pwm mode with wrap after top match
// - prescale code zero stops, codes 1..15 divide by 1 to 16384
module dual_pwm_timer (
	input  wire logic                     clk,
	input  wire logic                     rst,
	input  wire pwm_timer_pkg::reg_req_t  bus,
	output logic                    [7:0] rd_data,
	input  wire logic                     fast_clock_tick,
	input  wire logic                     pll_is_system_clock,
	output logic                          pll_run,
	output pwm_timer_pkg::pwm_pair_t      channel_a,
	output pwm_timer_pkg::pwm_pair_t      channel_b
);
	import pwm_timer_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [7:0]   count_value;
		logic [7:0]   top_compare_value;
		output_mode_t mode_a;
		output_mode_t mode_b;
		logic         channel_a_pwm_on;
		logic         channel_b_pwm_on;
		logic         clear_on_top;
		logic [3:0]   prescale_select;
		logic [13:0]  prescale_count;
		logic         pll_on;
		logic         fast_clock_select;
		logic [11:0]  lock_count;
		logic         lock_flag;
		logic [2:0]   sync1;
		logic [2:0]   sync2;
		logic [2:0]   flags;
		logic [1:0]   level;
		logic [1:0]   delayed;
		logic [1:0]   held;
		logic [1:0]   rise_ok;
		logic [1:0]   normal_out;
		pwm_pair_t    out_a;
		pwm_pair_t    out_b;
		logic [7:0]   rd_data;
	} timer_state_t;

	timer_state_t s;
	timer_state_t next_s;

	logic [7:0] active_a;
	logic [7:0] active_b;
	logic [7:0] shown_a;
	logic [7:0] shown_b;
	logic       wr_a;
	logic       wr_b;
	logic       top_event;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
		hit = (a == b);
	endfunction

	function automatic logic prescale_tick(input logic [13:0] cnt,
		input logic [3:0] sel);
		logic [13:0] mask;
		mask = 14'h0000;
		if (sel == 4'h0) begin
			prescale_tick = 1'b0;
		end else begin
			mask = 14'(({14'h0000, 1'b1} << (sel - 4'h1)) - 15'h0001);
			prescale_tick = ((cnt & mask) == mask);
		end
	endfunction

	function automatic logic [1:0] normal_action(input output_mode_t m,
		input logic lvl);
		unique case (m)
			MODE_OFF:    normal_action = {1'b0, lvl};
			MODE_TOGGLE: normal_action = {1'b1, ~lvl};
			MODE_CLEAR:  normal_action = {1'b1, 1'b0};
			MODE_SET:    normal_action = {1'b1, 1'b1};
		endcase
	endfunction

	function automatic pwm_pair_t drive(input output_mode_t m,
		input logic pwm, input logic [7:0] cmp, input logic [7:0] top,
		input logic dly, input logic hld, input logic norm);
		pwm_pair_t p;
		logic      rise_true;
		logic      rise_inv;
		logic      at_zero;
		logic      at_top;
		p = '0;
		// high only after raw level has stood a prescaled cycle
		rise_true = dly & hld;
		rise_inv  = ~dly & ~hld;
		at_zero   = hit(cmp, 8'h00);
		at_top    = hit(cmp, top);
		if (!pwm) begin
			p.true_on  = (m != MODE_OFF);
			p.true_out = norm;
		end else begin
			unique case (m)
				MODE_OFF: begin
					p = '0;
				end
				MODE_TOGGLE: begin
					p.true_on  = 1'b1;
					p.inv_on   = 1'b1;
					p.true_out = rise_true;
					p.inv_out  = rise_inv;
					if (at_zero) begin
						p.true_out = 1'b0;
						p.inv_out  = 1'b1;
					end else if (at_top) begin
						p.true_out = 1'b1;
						p.inv_out  = 1'b0;
					end
				end
				MODE_CLEAR: begin
					p.true_on  = 1'b1;
					p.true_out = dly;
					if (at_zero)
						p.true_out = 1'b0;
					else if (at_top)
						p.true_out = 1'b1;
				end
				MODE_SET: begin
					p.true_on  = 1'b1;
					p.true_out = rise_inv;
					if (at_zero)
						p.true_out = 1'b1;
					else if (at_top)
						p.true_out = 1'b0;
				end
			endcase
		end
		drive = p;
	endfunction

	// ----------------------------------------
	// compare buffers
	// ----------------------------------------
	assign wr_a = bus.wr && (bus.addr == `ADDR_CHANNEL_A_COMPARE);
	assign wr_b = bus.wr && (bus.addr == `ADDR_CHANNEL_B_COMPARE);

	compare_store u_compare_store (
		.clk      (clk),
		.rst      (rst),
		.wr_a     (wr_a),
		.wr_b     (wr_b),
		.wdata    (bus.wdata),
		.pwm_a    (s.channel_a_pwm_on),
		.pwm_b    (s.channel_b_pwm_on),
		.latch    (top_event),
		.active_a (active_a),
		.active_b (active_b),
		.shown_a  (shown_a),
		.shown_b  (shown_b)
	);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	logic       pll_eff;
	logic       src_tick;
	logic       ptick;
	logic       wrap;
	logic [7:0] count_next;
	logic [2:0] events;
	logic [1:0] act_a;
	logic [1:0] act_b;

	always_comb begin
		next_s     = s;
		pll_eff    = s.pll_on | pll_is_system_clock;
		// fast tick stands in for the pll clock; no second domain
		src_tick   = s.fast_clock_select ? fast_clock_tick : 1'b1;
		ptick      = src_tick &&
			prescale_tick(s.prescale_count, s.prescale_select);
		wrap       = hit(s.count_value, s.top_compare_value) &&
			(s.clear_on_top || s.channel_a_pwm_on ||
			s.channel_b_pwm_on);
		count_next = wrap ? 8'h00 : s.count_value + 8'h01;
		top_event  = 1'b0;
		events     = 3'b000;
		act_a      = 2'b00;
		act_b      = 2'b00;

		// prescaler runs on source ticks
		if (src_tick)
			next_s.prescale_count = s.prescale_count + 14'h0001;

		// counting; matches only arise here, never from writes
		if (ptick) begin
			next_s.count_value = count_next;
			top_event = hit(count_next, s.top_compare_value);
			events[`FLAG_OVERFLOW_BIT] = (wrap ||
				(s.count_value == 8'hFF)) && !(hit(s.count_value,
				s.top_compare_value) && !wrap && 1'b0);
			events[`FLAG_MATCH_A_BIT] = hit(count_next, active_a);
			events[`FLAG_MATCH_B_BIT] = hit(count_next, active_b);
			if (hit(count_next, active_a))
				next_s.level[1] = 1'b0;
			else if (hit(count_next, 8'h01))
				next_s.level[1] = 1'b1;
			else if (hit(count_next, 8'h00))
				next_s.level[1] = 1'b0;
			if (hit(count_next, active_b))
				next_s.level[0] = 1'b0;
			else if (hit(count_next, 8'h01))
				next_s.level[0] = 1'b1;
			else if (hit(count_next, 8'h00))
				next_s.level[0] = 1'b0;
			// settled level, picked up one prescaled cycle late
			next_s.held = s.level;
			if (events[`FLAG_MATCH_A_BIT])
				act_a = normal_action(s.mode_a, s.normal_out[1]);
			if (events[`FLAG_MATCH_B_BIT])
				act_b = normal_action(s.mode_b, s.normal_out[0]);
		end
		// falling edges lag one source cycle
		if (src_tick) begin
			next_s.delayed = s.level;
			next_s.rise_ok = s.held;
		end

		// two-stage delay from match to flag
		next_s.sync1 = events;
		next_s.sync2 = s.sync1;

		// pll lock timing
		if (!pll_eff) begin
			next_s.lock_count        = 12'h000;
			next_s.lock_flag         = 1'b0;
			next_s.fast_clock_select = 1'b0;
		end else if (!s.lock_flag) begin
			next_s.lock_count = s.lock_count + 12'h001;
			if (s.lock_count == 12'(`LOCK_CYCLES - 1))
				next_s.lock_flag = 1'b1;
		end

		// register writes
		if (bus.wr) begin
			unique case (bus.addr)
				`ADDR_PLL_CONTROL_STATUS: begin
					next_s.pll_on = bus.wdata[`PLL_ON_BIT];
					// no guard on lock; software waits for it
					next_s.fast_clock_select =
						bus.wdata[`PLL_FAST_SELECT_BIT] &&
						(bus.wdata[`PLL_ON_BIT] ||
						pll_is_system_clock);
				end
				`ADDR_TIMER_CONTROL_A: begin
					next_s.mode_a = output_mode_t'(
						bus.wdata[`CTLA_MODE_A_LSB +: 2]);
					next_s.mode_b = output_mode_t'(
						bus.wdata[`CTLA_MODE_B_LSB +: 2]);
					next_s.channel_a_pwm_on =
						bus.wdata[`CTLA_PWM_A_BIT];
					next_s.channel_b_pwm_on =
						bus.wdata[`CTLA_PWM_B_BIT];
					if (bus.wdata[`CTLA_FORCE_A_BIT] &&
						!bus.wdata[`CTLA_PWM_A_BIT])
						act_a = normal_action(output_mode_t'(
							bus.wdata[`CTLA_MODE_A_LSB +: 2]),
							s.normal_out[1]);
					if (bus.wdata[`CTLA_FORCE_B_BIT] &&
						!bus.wdata[`CTLA_PWM_B_BIT])
						act_b = normal_action(output_mode_t'(
							bus.wdata[`CTLA_MODE_B_LSB +: 2]),
							s.normal_out[0]);
				end
				`ADDR_TIMER_CONTROL_B: begin
					next_s.clear_on_top =
						bus.wdata[`CTLB_CLEAR_TOP_BIT];
					next_s.prescale_select = bus.wdata[3:0];
					if (bus.wdata[`CTLB_PRESCALE_RST])
						next_s.prescale_count = 14'h0000;
				end
				`ADDR_COUNT_VALUE: begin
					next_s.count_value = bus.wdata;
				end
				`ADDR_TOP_COMPARE: begin
					next_s.top_compare_value = bus.wdata;
				end
				`ADDR_FLAGS: begin
					next_s.flags = s.flags & ~bus.wdata[2:0];
				end
				default: begin
				end
			endcase
		end
		if (act_a[1])
			next_s.normal_out[1] = act_a[0];
		if (act_b[1])
			next_s.normal_out[0] = act_b[0];
		// a late event beats a clear in the same cycle
		next_s.flags = next_s.flags | s.sync2;

		// outputs
		next_s.out_a = drive(s.mode_a, s.channel_a_pwm_on, active_a,
			s.top_compare_value, s.delayed[1], s.rise_ok[1],
			s.normal_out[1]);
		next_s.out_b = drive(s.mode_b, s.channel_b_pwm_on, active_b,
			s.top_compare_value, s.delayed[0], s.rise_ok[0],
			s.normal_out[0]);

		// register reads, data one cycle later
		next_s.rd_data = 8'h00;
		if (bus.rd) begin
			unique case (bus.addr)
				`ADDR_PLL_CONTROL_STATUS:
					next_s.rd_data = {5'h00, s.fast_clock_select,
						pll_eff, s.lock_flag};
				`ADDR_TIMER_CONTROL_A:
					next_s.rd_data = {s.mode_a, s.mode_b, 2'b00,
						s.channel_a_pwm_on, s.channel_b_pwm_on};
				`ADDR_TIMER_CONTROL_B:
					next_s.rd_data = {s.clear_on_top, 3'b000,
						s.prescale_select};
				`ADDR_COUNT_VALUE:
					next_s.rd_data = s.count_value;
				`ADDR_TOP_COMPARE:
					next_s.rd_data = s.top_compare_value;
				`ADDR_CHANNEL_A_COMPARE:
					next_s.rd_data = shown_a;
				`ADDR_CHANNEL_B_COMPARE:
					next_s.rd_data = shown_b;
				`ADDR_FLAGS:
					next_s.rd_data = {5'h00, s.flags};
				default:
					next_s.rd_data = 8'h00;
			endcase
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s                   <= '0;
			s.count_value       <= `COUNT_RESET;
			s.top_compare_value <= `TOP_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign rd_data   = s.rd_data;
	assign pll_run   = s.pll_on | pll_is_system_clock;
	assign channel_a = s.out_a;
	assign channel_b = s.out_b;

endmodule

// ### test/pwm_timer_assertions.sv
`timescale 1ns/100ps

module pwm_timer_checker (
	input  wire logic                     clk,
	input  wire logic                     rst,
	input  wire pwm_timer_pkg::reg_req_t  bus,
	input  wire logic               [7:0] rd_data,
	input  wire logic                     fast_clock_tick,
	input  wire logic                     pll_is_system_clock,
	input  wire logic                     pll_run,
	input  wire pwm_timer_pkg::pwm_pair_t channel_a,
	input  wire pwm_timer_pkg::pwm_pair_t channel_b
);
	import pwm_timer_pkg::*;

	// ----------------------------------------
	// shadows of what software last wrote
	// ----------------------------------------
	logic [7:0] top_s;
	logic [7:0] cmp_s;
	logic [1:0] mode_a;
	logic [1:0] mode_b;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			top_s <= 8'hFF;
			cmp_s <= 8'h00;
			mode_a <= 2'h0;
			mode_b <= 2'h0;
		end else if (bus.wr) begin
			if (bus.addr == 8'h2B)
				top_s <= bus.wdata;
			if (bus.addr == 8'h2D)
				cmp_s <= bus.wdata;
			if (bus.addr == 8'h30) begin
				mode_a <= bus.wdata[7:6];
				mode_b <= bus.wdata[5:4];
			end
		end
	end

	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	shoot_a_a: assert property (!(channel_a.true_on && channel_a.true_out
		&& channel_a.inv_on && channel_a.inv_out)) else $error("pair a overlap");
	shoot_b_a: assert property (!(channel_b.true_on && channel_b.true_out
		&& channel_b.inv_on && channel_b.inv_out)) else $error("pair b overlap");
	pll_resv_a: assert property ($past(bus.rd) && $past(bus.addr) == 8'h29
		|-> rd_data[7:3] == 5'h00) else $error("pll reserved bits set");
	sel_pll_a: assert property ($past(bus.rd) && $past(bus.addr) == 8'h29
		|-> !rd_data[2] || rd_data[1]) else $error("fast select without pll");
	lock_pll_a: assert property ($past(bus.rd) && $past(bus.addr) == 8'h29
		|-> !rd_data[0] || rd_data[1]) else $error("lock without pll");
	strap_on_a: assert property (pll_is_system_clock |-> pll_run)
		else $error("pll off while system clock");
	top_back_a: assert property ($past(bus.rd) && $past(bus.addr) == 8'h2B
		|-> rd_data == $past(top_s)) else $error("top readback wrong");
	cmp_back_a: assert property ($past(bus.rd) && $past(bus.addr) == 8'h2D
		|-> rd_data == $past(cmp_s)) else $error("compare readback wrong");
	off_pair_a: assert property (mode_a == 2'h0 && $past(mode_a, 3) == 2'h0
		|-> !channel_a.true_on && !channel_a.inv_on) else $error("pair a on");
	inv_off_b_a: assert property (mode_b[1] && $past(mode_b[1], 3)
		|-> !channel_b.inv_on) else $error("inverted b driven");
endmodule

bind dual_pwm_timer pwm_timer_checker chk (
	.clk                 (clk),
	.rst                 (rst),
	.bus                 (bus),
	.rd_data             (rd_data),
	.fast_clock_tick     (fast_clock_tick),
	.pll_is_system_clock (pll_is_system_clock),
	.pll_run             (pll_run),
	.channel_a           (channel_a),
	.channel_b           (channel_b)
);

// ### test/switch_driver_model.sv
`timescale 1ns/100ps

module switch_driver_model (
	input  wire logic                     clk,
	input  wire logic                     rst,
	input  wire pwm_timer_pkg::pwm_pair_t pair,
	output logic                          shoot
);
	import pwm_timer_pkg::*;

	// ----------------------------------------
	// half bridge gates
	// ----------------------------------------
	// a released pin is pulled down at the gate driver, so it switches off
	logic hi_gate;
	logic lo_gate;

	assign hi_gate = pair.true_on & pair.true_out;
	assign lo_gate = pair.inv_on & pair.inv_out;

	// sticky: one overlapping cycle already wrecks the bridge
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			shoot <= 1'b0;
		else if (hi_gate & lo_gate)
			shoot <= 1'b1;
	end
endmodule

// ### test/tb.sv
`timescale 1ns/100ps

module tb;
	import pwm_timer_pkg::*;

	logic       clk;
	logic       rst;
	logic       fast_clock_tick;
	logic       pll_is_system_clock;
	logic       tick_en;
	logic       pll_run;
	logic       shoot_a;
	logic       shoot_b;
	reg_req_t   bus;
	logic [7:0] rd_data;
	logic [7:0] d;
	logic [7:0] top;
	logic [7:0] cmp;
	logic [1:0] m;
	logic [3:0] ps;
	logic       ex;
	pwm_pair_t  channel_a;
	pwm_pair_t  channel_b;
	logic [31:0] seed;
	int         err_count;
	int         total_checks;
	int         per;
	int         hi;
	int         n;

	dual_pwm_timer uut (.clk(clk), .rst(rst), .bus(bus), .rd_data(rd_data),
		.fast_clock_tick(fast_clock_tick),
		.pll_is_system_clock(pll_is_system_clock), .pll_run(pll_run),
		.channel_a(channel_a), .channel_b(channel_b));
	switch_driver_model drv_a (.clk(clk), .rst(rst), .pair(channel_a),
		.shoot(shoot_a));
	switch_driver_model drv_b (.clk(clk), .rst(rst), .pair(channel_b),
		.shoot(shoot_b));

	// ----------------------------------------
	// clock and fast tick
	// ----------------------------------------
	always #20 clk = ~clk;
	always @(posedge clk) fast_clock_tick <= tick_en & ~fast_clock_tick;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %0h seen %0h", name, exp, seen);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		bus.addr <= a;
		bus.wdata <= v;
		bus.wr <= 1'b1;
		@(posedge clk);
		bus.wr <= 1'b0;
		@(posedge clk);
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clk);
		bus.rd <= 1'b0;
		#1;
		d = rd_data;
		@(posedge clk);
	endtask

	// waits for a rising true output, counting source ticks on the way
	task automatic edge_wait();
		logic prev;
		int   k;
		per = 0;
		hi = 0;
		k = 0;
		do begin
			prev = channel_a.true_out;
			@(posedge clk);
			#1;
			k++;
			per += tick_en ? fast_clock_tick : 1'b1;
			if (channel_a.true_out || channel_a.inv_out)
				hi += tick_en ? fast_clock_tick : 1'b1;
		end while (!(channel_a.true_out && !prev) && k < 5000);
		if (k >= 5000) begin
			err_count++;
			end_of_test();
		end
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		clk = 0;
		rst = 1;
		bus = '0;
		tick_en = 0;
		fast_clock_tick = 0;
		pll_is_system_clock = 0;
		seed = 32'hB11A8275;
		err_count = 0;
		total_checks = 0;
		repeat (16) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		rd(8'h29);
		check("pll reset", d, 8'h00);
		rd(8'h2B);
		check("top reset", d, 8'hFF);
		rd(8'h55);
		check("unmapped", d, 8'h00);
		pll_is_system_clock <= 1;
		wr(8'h29, 8'h00);
		rd(8'h29);
		check("pll strap", d, 8'h02);
		check("pll run", pll_run, 1'b1);
		pll_is_system_clock <= 0;
		wr(8'h29, 8'h04);
		rd(8'h29);
		check("select refused", d, 8'h00);
		wr(8'h29, 8'hFA);
		rd(8'h29);
		check("pll on", d, 8'h02);
		n = 0;
		do begin
			rd(8'h29);
			n++;
		end while (d[0] !== 1'b1 && n < 2000);
		check("lock time", n <= 1260, 1'b1);
		// count stopped: a software write to equal values is no match
		wr(8'h2F, 8'h80);
		wr(8'h2A, 8'hFF);
		wr(8'h2B, 8'h05);
		wr(8'h2D, 8'h05);
		wr(8'h2E, 8'h05);
		repeat (8) @(posedge clk);
		rd(8'h2A);
		check("no soft match", d, 8'h00);
		wr(8'h2F, 8'h81);
		repeat (20) @(posedge clk);
		rd(8'h2A);
		check("top overflow", d[2], 1'b1);
		repeat (6) begin
			rd(8'h2E);
			check("top wrap", d <= 8'h05, 1'b1);
		end
		for (int f = 0; f < 2; f++) begin
			if (f) begin
				tick_en <= 1;
				wr(8'h29, 8'h06);
			end
			repeat (3) begin
				top = 8'(4 + rnd() % 17);
				// compare of one would clash with the set at one
				cmp = 8'(2 + rnd() % (top - 2));
				ps = 4'(1 + rnd() % 3);
				m = 2'(1 + rnd() % 3);
				wr(8'h2B, top);
				wr(8'h2D, cmp);
				wr(8'h2C, cmp);
				rd(8'h2D);
				check("compare readback", d, cmp);
				wr(8'h2F, {4'h0, ps});
				wr(8'h30, {2'b01, m, 4'b0011});
				wr(8'h2A, 8'hFF);
				edge_wait();
				edge_wait();
				edge_wait();
				check("period", per, (top + 1) << (ps - 1));
				check("dead time", hi, (top - 1) << (ps - 1));
				rd(8'h2A);
				check("pwm flags", d[2:1], 2'b11);
			end
		end
		for (int i = 0; i < 6; i++) begin
			m = 2'(1 + i / 2);
			cmp = i[0] ? top : 8'h00;
			wr(8'h30, {m, 4'b0000, 2'b10});
			wr(8'h2D, cmp);
			repeat (400) @(posedge clk);
			ex = (cmp != 8'h00) ^ (m == 2'b11);
			n = 0;
			repeat (200) begin
				@(posedge clk);
				#1;
				n += (channel_a.true_out !== ex);
				n += (m == 2'b01 && channel_a.inv_out !== !ex);
			end
			check("static level", n, 0);
		end
		check("overlap a", shoot_a, 1'b0);
		check("overlap b", shoot_b, 1'b0);
		end_of_test();
	end
endmodule
